// File: design/qrb_host.v
// Functional notes
// - Quad enable must be set before quad reads
// - Host changes on falling, device samples rising
// - Quad output read: opcode, address, eight dummies
// - Quad io read: quad address, mode, dummies
// - Host may raise select during data
// - Host drives lines during mode clocks
// - Send non one-zero when not continuous
// - No wrap for quad io in four-line mode
// - Wrap frame: opcode, 24 dummies, wrap byte
// - Bit four one disables; length field sizes
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`include "qrb_defines.vh"
`default_nettype none

module qrb_host #(
	parameter HALF = `QRB_SCLK_NS / (2 * `QRB_PCLK_NS)
) (
	input wire pclk, // Block clock
	input wire presetn, // Async reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [`QRB_ADDR_W-1:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error on unmapped address
	output reg sclk, // Link clock to the flash
	output reg cs_n, // Chip select, active low
	output reg [3:0] io_o, // io_line_3..0 drive value
	output reg [3:0] io_oe_n, // io_line_3..0 enable, low drives
	input wire [3:0] io_i // io_line_3..0 pin level
);

	// ------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------
	localparam S_IDLE = 3'h0;
	localparam S_CMD = 3'h1;
	localparam S_ADDR = 3'h2;
	localparam S_MODE = 3'h3;
	localparam S_DUMMY = 3'h4;
	localparam S_DATA = 3'h5;
	localparam S_WRAP = 3'h6;
	localparam S_END = 3'h7;

	reg [2:0] state_reg;
	reg [31:0] sh_reg;
	reg [5:0] cnt_reg;
	reg quad_reg;
	reg [1:0] cmd_reg;
	reg qpi_reg;
	reg cont_reg;
	reg qe_reg;
	reg [23:0] addr_reg;
	reg [7:0] wrap_reg;
	reg [3:0] dum_reg;
	reg [15:0] len_reg;
	reg [15:0] rem_reg;
	reg [3:0] rx_nib_reg;
	reg [7:0] rx_data_reg;
	reg rx_valid_reg;
	reg cont_active_reg;
	reg refused_reg;
	reg go_reg;
	reg stop_reg;

	wire [3:0] io_s;
	wire tick;
	wire apb_done;
	wire wr;
	wire rd;
	wire rise;
	wire fall;
	wire stall;
	wire [5:0] dum_ext;
	wire [5:0] dum_qpi;
	wire busy;
	wire bad_req;

	// ------------------------------------------------------------------
	// Pin sampling and link clock enable
	// ------------------------------------------------------------------
	qrb_sync #(.W(4)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d(io_i),
		.q(io_s)
	);

	// Holding the link clock is the back-pressure: no byte is overwritten
	// An abort lifts the hold, else a cut frame would never close
	assign stall = (state_reg == S_DATA) && rx_valid_reg && !sclk &&
		(cnt_reg == `QRB_CLK_NIB) && !stop_reg;

	qrb_clkdiv #(.HALF(HALF)) u_div (
		.clk(pclk),
		.rst_n(presetn),
		.en(!stall),
		.tick(tick)
	);

	assign rise = tick && !sclk && (state_reg != S_IDLE) &&
		(state_reg != S_END);
	assign fall = tick && sclk;
	assign busy = (state_reg != S_IDLE);
	assign dum_ext = {2'b00, dum_reg};
	assign dum_qpi = (dum_ext > `QRB_CLK_MODE) ?
		dum_ext - `QRB_CLK_MODE : 6'h00;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function [3:0] pres;
		input [31:0] s;
		input q;
		begin
			pres = q ? s[31:28] : {3'b000, s[31]};
		end
	endfunction

	function mapped;
		input [`QRB_ADDR_W-1:0] a;
		begin
			mapped = (a == `QRB_OFF_CTRL) || (a == `QRB_OFF_ADDR) ||
				(a == `QRB_OFF_CFG) || (a == `QRB_OFF_LEN) ||
				(a == `QRB_OFF_STAT) || (a == `QRB_OFF_DATA);
		end
	endfunction

	// Enter a phase; drive only io_line_0 unless quad
	task load;
		input [2:0] st;
		input [31:0] s;
		input [5:0] c;
		input q;
		input drv;
		begin
			state_reg <= st;
			sh_reg <= s;
			cnt_reg <= c;
			quad_reg <= q;
			io_o <= pres(s, q);
			io_oe_n <= !drv ? 4'hF : (q ? 4'h0 : 4'hE);
		end
	endtask

	// ------------------------------------------------------------------
	// APB slave, one wait state
	// ------------------------------------------------------------------
	assign apb_done = psel && penable && pready;
	assign wr = apb_done && pwrite && mapped(paddr);
	assign rd = apb_done && !pwrite && mapped(paddr);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !mapped(paddr);
			prdata <= 32'h00000000;
			if (!pwrite) begin
				case (paddr)
				`QRB_OFF_CTRL:
					prdata <= {26'h0, qe_reg, cont_reg, qpi_reg,
						cmd_reg, 1'b0};
				`QRB_OFF_ADDR: prdata <= {8'h00, addr_reg};
				`QRB_OFF_CFG: prdata <= {20'h0, dum_reg, wrap_reg};
				`QRB_OFF_LEN: prdata <= {16'h0000, len_reg};
				`QRB_OFF_STAT:
					prdata <= {28'h0, refused_reg, cont_active_reg,
						rx_valid_reg, busy};
				`QRB_OFF_DATA: prdata <= {24'h000000, rx_data_reg};
				default: prdata <= 32'h00000000;
				endcase
			end
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Reads need quad enable; a skipped opcode only suits quad io read
	assign bad_req = ((cmd_reg == `QRB_CMD_QOR ||
		cmd_reg == `QRB_CMD_QIO) && !qe_reg) ||
		(cmd_reg == `QRB_CMD_QOR && qpi_reg) ||
		(cmd_reg == `QRB_CMD_WRAP && qpi_reg) ||
		(cont_active_reg && cmd_reg != `QRB_CMD_QIO &&
		cmd_reg != `QRB_CMD_CRST);

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= `QRB_CMD_QOR;
			qpi_reg <= 1'b0;
			cont_reg <= 1'b0;
			qe_reg <= 1'b0;
			addr_reg <= 24'h000000;
			wrap_reg <= `QRB_WRAP_DEF;
			dum_reg <= `QRB_DUM_DEF;
			len_reg <= `QRB_LEN_DEF;
			go_reg <= 1'b0;
			stop_reg <= 1'b0;
		end else begin
			if (wr && paddr == `QRB_OFF_CTRL) begin
				if (!busy) begin
					cmd_reg <= pwdata[`QRB_CTRL_CMD_HI:`QRB_CTRL_CMD_LO];
					qpi_reg <= pwdata[`QRB_CTRL_QPI];
					cont_reg <= pwdata[`QRB_CTRL_CONT];
					qe_reg <= pwdata[`QRB_CTRL_QE];
				end
				go_reg <= pwdata[`QRB_CTRL_GO] && !busy;
				stop_reg <= pwdata[`QRB_CTRL_STOP] && busy;
			end else begin
				// A start is used up at its tick, refused or not
				if (busy || tick)
					go_reg <= 1'b0;
				if (!busy)
					stop_reg <= 1'b0;
			end
			if (wr && !busy && paddr == `QRB_OFF_ADDR)
				addr_reg <= pwdata[23:0];
			if (wr && !busy && paddr == `QRB_OFF_CFG) begin
				wrap_reg <= pwdata[`QRB_CFG_WRAP_HI:0];
				dum_reg <= pwdata[`QRB_CFG_DUM_HI:`QRB_CFG_DUM_LO];
			end
			if (wr && !busy && paddr == `QRB_OFF_LEN)
				len_reg <= pwdata[15:0];
		end
	end

	// ------------------------------------------------------------------
	// Link sequencer
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= S_IDLE;
			sh_reg <= 32'h00000000;
			cnt_reg <= 6'h00;
			quad_reg <= 1'b0;
			sclk <= 1'b0;
			cs_n <= 1'b1;
			io_o <= 4'h0;
			io_oe_n <= 4'hF;
			rem_reg <= 16'h0000;
			rx_nib_reg <= 4'h0;
			rx_data_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			cont_active_reg <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			// A delivered byte wins over the clearing read
			if (rd && paddr == `QRB_OFF_DATA)
				rx_valid_reg <= 1'b0;
			if (wr && paddr == `QRB_OFF_STAT &&
					pwdata[`QRB_ST_REFUSED])
				refused_reg <= 1'b0;
			if (rise) begin
				sclk <= 1'b1;
				cnt_reg <= cnt_reg - 6'h01;
				if (state_reg == S_DATA) begin
					rx_nib_reg <= io_s;
					if (cnt_reg == 6'h01) begin
						rx_data_reg <= {rx_nib_reg, io_s};
						rx_valid_reg <= 1'b1;
					end
				end
			end
			if (tick && state_reg == S_IDLE && go_reg) begin
				if (bad_req) begin
					refused_reg <= 1'b1;
				end else begin
					cs_n <= 1'b0;
					rem_reg <= (len_reg == 16'h0000) ? 16'h0000 :
						len_reg - 16'h0001;
					if (cmd_reg == `QRB_CMD_QIO && cont_active_reg)
						load(S_ADDR, {addr_reg, 8'h00},
							`QRB_CLK_AD4, 1'b1, 1'b1);
					else if (cmd_reg == `QRB_CMD_QIO && qpi_reg)
						load(S_CMD, {`QRB_OP_QIO, 24'h0},
							`QRB_CLK_OP4, 1'b1, 1'b1);
					else if (cmd_reg == `QRB_CMD_QIO)
						load(S_CMD, {`QRB_OP_QIO, 24'h0},
							`QRB_CLK_OP1, 1'b0, 1'b1);
					else if (cmd_reg == `QRB_CMD_QOR)
						load(S_CMD, {`QRB_OP_QOR, 24'h0},
							`QRB_CLK_OP1, 1'b0, 1'b1);
					else if (cmd_reg == `QRB_CMD_WRAP)
						load(S_CMD, {`QRB_OP_WRAP, 24'h0},
							`QRB_CLK_OP1, 1'b0, 1'b1);
					else
						load(S_CMD, {`QRB_OP_CRST, 24'h0},
							`QRB_CLK_OP1, 1'b0, 1'b1);
				end
			end
			if (tick && state_reg == S_END) begin
				cs_n <= 1'b1;
				state_reg <= S_IDLE;
			end
			if (fall) begin
				sclk <= 1'b0;
				if (stop_reg) begin
					state_reg <= S_END;
					io_oe_n <= 4'hF;
				end else if (cnt_reg != 6'h00) begin
					sh_reg <= quad_reg ? {sh_reg[27:0], 4'h0} :
						{sh_reg[30:0], 1'b0};
					io_o <= pres(quad_reg ? {sh_reg[27:0], 4'h0} :
						{sh_reg[30:0], 1'b0}, quad_reg);
				end else begin
					case (state_reg)
					S_CMD: begin
						if (cmd_reg == `QRB_CMD_QOR)
							load(S_ADDR, {addr_reg, 8'h00},
								`QRB_CLK_AD1, 1'b0, 1'b1);
						else if (cmd_reg == `QRB_CMD_QIO)
							load(S_ADDR, {addr_reg, 8'h00},
								`QRB_CLK_AD4, 1'b1, 1'b1);
						else if (cmd_reg == `QRB_CMD_WRAP)
							load(S_WRAP, {24'h000000, wrap_reg},
								`QRB_CLK_WRAP, 1'b0, 1'b1);
						else begin
							load(S_END, 32'h0, 6'h00, 1'b0, 1'b0);
							cont_active_reg <= 1'b0;
						end
					end
					S_ADDR: begin
						if (cmd_reg == `QRB_CMD_QOR)
							load(S_DUMMY, 32'h0, `QRB_CLK_QORD,
								1'b0, 1'b0);
						else
							load(S_MODE, {cont_reg ? `QRB_MODE_CONT :
								`QRB_MODE_NORM, 24'h0},
								`QRB_CLK_MODE, 1'b1, 1'b1);
					end
					S_MODE: begin
						cont_active_reg <= cont_reg;
						if ((qpi_reg ? dum_qpi : dum_ext) == 6'h00)
							load(S_DATA, 32'h0, `QRB_CLK_NIB,
								1'b1, 1'b0);
						else
							load(S_DUMMY, 32'h0, qpi_reg ? dum_qpi :
								dum_ext, 1'b1, 1'b0);
					end
					S_DUMMY:
						load(S_DATA, 32'h0, `QRB_CLK_NIB, 1'b1, 1'b0);
					S_DATA: begin
						if (rem_reg == 16'h0000)
							load(S_END, 32'h0, 6'h00, 1'b0, 1'b0);
						else begin
							rem_reg <= rem_reg - 16'h0001;
							cnt_reg <= `QRB_CLK_NIB;
						end
					end
					S_WRAP:
						load(S_END, 32'h0, 6'h00, 1'b0, 1'b0);
					default:
						load(S_END, 32'h0, 6'h00, 1'b0, 1'b0);
					endcase
				end
			end
		end
	end

endmodule

`default_nettype wire

// File: design/qrb_defines.vh
`ifndef QRB_DEFINES_VH
`define QRB_DEFINES_VH

// ----------------------------------------------------------------------
// Register map (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define QRB_ADDR_W 8
`define QRB_OFF_CTRL 8'h00
`define QRB_OFF_ADDR 8'h04
`define QRB_OFF_CFG 8'h08
`define QRB_OFF_LEN 8'h0C
`define QRB_OFF_STAT 8'h10
`define QRB_OFF_DATA 8'h14

// CTRL fields
`define QRB_CTRL_GO 0
`define QRB_CTRL_CMD_LO 1
`define QRB_CTRL_CMD_HI 2
`define QRB_CTRL_QPI 3
`define QRB_CTRL_CONT 4
`define QRB_CTRL_QE 5
`define QRB_CTRL_STOP 6

// CFG fields
`define QRB_CFG_WRAP_HI 7
`define QRB_CFG_DUM_LO 8
`define QRB_CFG_DUM_HI 11

// STATUS fields
`define QRB_ST_BUSY 0
`define QRB_ST_VALID 1
`define QRB_ST_CONT 2
`define QRB_ST_REFUSED 3

// Reset values
`define QRB_WRAP_DEF 8'h10
`define QRB_DUM_DEF 4'h4
`define QRB_LEN_DEF 16'h0001

// ----------------------------------------------------------------------
// Commands
// ----------------------------------------------------------------------
`define QRB_CMD_QOR 2'h0
`define QRB_CMD_QIO 2'h1
`define QRB_CMD_WRAP 2'h2
`define QRB_CMD_CRST 2'h3

`define QRB_OP_QOR 8'h6B
`define QRB_OP_QIO 8'hEB
`define QRB_OP_WRAP 8'h77
`define QRB_OP_CRST 8'hFF

`define QRB_MODE_CONT 8'h20
`define QRB_MODE_NORM 8'h00

// Link clock counts per phase
`define QRB_CLK_OP1 6'h08
`define QRB_CLK_OP4 6'h02
`define QRB_CLK_AD1 6'h18
`define QRB_CLK_AD4 6'h06
`define QRB_CLK_MODE 6'h02
`define QRB_CLK_QORD 6'h08
`define QRB_CLK_WRAP 6'h20
`define QRB_CLK_NIB 6'h02

// Link timing
`define QRB_PCLK_NS 100
`define QRB_SCLK_NS 800

`endif

// File: design/qrb_sync.v
`default_nettype none

module qrb_sync #(
	parameter W = 4
) (
	input wire clk, // Sampling clock
	input wire rst_n, // Async reset, active low
	input wire [W-1:0] d, // Asynchronous inputs
	output wire [W-1:0] q // Synchronised outputs
);

	// ------------------------------------------------------------------
	// Two flops per bit; the first is read only by the second
	// ------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg s1_reg;
			reg s2_reg;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
				end else begin
					s1_reg <= d[i];
					s2_reg <= s1_reg;
				end
			end
			assign q[i] = s2_reg;
		end
	endgenerate

endmodule

`default_nettype wire

// File: design/qrb_clkdiv.v
`default_nettype none

module qrb_clkdiv #(
	parameter HALF = 4
) (
	input wire clk, // Block clock
	input wire rst_n, // Async reset, active low
	input wire en, // Count enable; low stalls the link
	output reg tick // One-cycle pulse every HALF enabled cycles
);

	reg [7:0] cnt_reg;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
			tick <= 1'b0;
		end else if (en) begin
			if (cnt_reg == HALF[7:0] - 8'h01) begin
				cnt_reg <= 8'h00;
				tick <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 8'h01;
				tick <= 1'b0;
			end
		end else begin
			tick <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// File: testbench/qrb_host_chk.sv
`default_nettype none
module qrb_host_chk #(
	parameter HALF = 4
) (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic sclk, // link clock
	input wire logic cs_n, // chip select
	input wire logic [3:0] io_o, // drive value
	input wire logic [3:0] io_oe_n // drive enable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [7:0] hcnt;
	logic [7:0] lcnt;
	// Low phase may stretch under back-pressure, so only a floor is known
	always @(posedge pclk or negedge presetn)
		if (!presetn) begin
			hcnt <= 8'h00;
			lcnt <= 8'h00;
		end else begin
			hcnt <= sclk ? hcnt + 8'h01 : 8'h00;
			lcnt <= sclk ? 8'h00 : lcnt + {7'h0, lcnt != 8'hFF};
		end
	property p_wait;
		$rose(psel && penable) |-> ##[1:2] pready;
	endproperty
	a_wait: assert property (p_wait) else $error("no ready");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_idle;
		cs_n && $past(cs_n) |-> io_oe_n == 4'hF && !sclk;
	endproperty
	a_idle: assert property (p_idle) else $error("lines held");
	property p_mode0;
		$changed(cs_n) |-> !sclk && !$past(sclk);
	endproperty
	a_mode0: assert property (p_mode0) else $error("select moved");
	property p_fall;
		!cs_n && !$past(cs_n) && $changed({io_o, io_oe_n}) |-> $fell(sclk);
	endproperty
	a_fall: assert property (p_fall) else $error("late drive");
	property p_high;
		$fell(sclk) |-> hcnt == HALF;
	endproperty
	a_high: assert property (p_high) else $error("high phase");
	property p_low;
		$rose(sclk) |-> lcnt >= HALF;
	endproperty
	a_low: assert property (p_low) else $error("low phase");
	property p_lines;
		io_oe_n == 4'hF || io_oe_n == 4'hE || io_oe_n == 4'h0;
	endproperty
	a_lines: assert property (p_lines) else $error("bad enable");
	property p_rst;
		$rose(presetn) |-> cs_n && !sclk && io_oe_n == 4'hF && !pready;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	c_frame: cover property ($fell(cs_n));
	c_err: cover property (pslverr);
	c_data: cover property ($rose(sclk) && !cs_n && io_oe_n == 4'hF);
endmodule
bind qrb_host qrb_host_chk #(.HALF(HALF)) u_chk(
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.sclk(sclk),
	.cs_n(cs_n),
	.io_o(io_o),
	.io_oe_n(io_oe_n)
);
`default_nettype wire

// File: testbench/qrb_flash.sv
`default_nettype none
module qrb_flash(
	input wire logic sclk, // link clock
	input wire logic cs_n, // chip select
	input wire logic four_line_command_mode, // four_line_command_mode
	input wire logic [3:0] dummy, // dummy clocks
	input wire logic wip, // internal cycle busy
	input wire logic [3:0] io, // line levels
	output logic [3:0] dq // device drive
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] op, mode, b;
	logic [7:0] wrapb = 8'h10;
	logic [23:0] adr, m;
	logic cont = 1'b0;
	logic hi;
	logic dat = 1'b0;
	int k, lf, d0;
	initial dq = 4'h0;
	function automatic logic [7:0] mem_byte(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
	endfunction
	always @(negedge cs_n) begin
		k = 0;
		hi = 1'b1;
		lf = cont ? 0 : (four_line_command_mode ? 2 : 8);
		op = cont ? 8'hEB : 8'h00;
	end
	// Released lines show the inverse, never a stale copy
	always @(posedge cs_n) begin
		dat = 1'b0;
		dq = ~dq;
	end
	always @(posedge sclk) if (!cs_n && !wip) begin
		if (k < lf)
			op = four_line_command_mode ? {op[3:0], io} : {op[6:0], io[0]};
		else if (op == 8'hEB && k < lf + 6)
			adr = {adr[19:0], io};
		else if (op == 8'hEB && k < lf + 8) begin
			mode = {mode[3:0], io};
			if (k == lf + 7) cont = mode[5:4] == 2'b10;
		end else if (op == 8'h6B && k < lf + 24)
			adr = {adr[22:0], io[0]};
		else if (op == 8'h77 && k >= lf + 24 && k < lf + 32)
			wrapb = {wrapb[6:0], io[0]};
		d0 = op == 8'h6B ? lf + 32 :
			lf + 8 + (four_line_command_mode ? dummy - 2 : dummy);
		if ((op == 8'h6B || op == 8'hEB) && k == d0 - 1) dat = 1'b1;
		k++;
	end
	always @(negedge sclk) if (!cs_n && dat) begin
		b = mem_byte(adr);
		dq = hi ? b[7:4] : b[3:0];
		if (!hi) begin
			m = (op == 8'hEB && !four_line_command_mode && !wrapb[4]) ?
				(24'h8 << wrapb[6:5]) - 24'h1 : 24'hFFFFFF;
			adr = (adr & ~m) | ((adr + 24'h1) & m);
		end
		hi = ~hi;
	end
endmodule
`default_nettype wire

// File: testbench/test_quad_read_burst_wrap.sv
`default_nettype none
module test_quad_read_burst_wrap;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 4;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, four_line_command_mode = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, sclk, cs_n, er;
	logic [3:0] io_o, io_oe_n, io_i, dq;
	logic [23:0] s;
	logic wip = 1'b0;
	logic [3:0] dm = 4'h4;
	int n_fail = 0, n_checks = 0, cyc = 0;
	initial forever #50 pclk = ~pclk;
	assign io_i = (io_o & ~io_oe_n) | (dq & io_oe_n);
	qrb_host #(.HALF(HALF)) dut(.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .io_o(io_o),
		.io_oe_n(io_oe_n), .io_i(io_i));
	qrb_flash u_fl(.sclk(sclk), .cs_n(cs_n), .four_line_command_mode(four_line_command_mode), .dummy(dm),
		.wip(wip), .io(io_i), .dq(dq));
	task automatic conclude;
		if (n_fail == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail++;
			conclude;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(r, e);
	endtask
	// The start waits for a divider tick, so busy may lag the write
	task automatic idle;
		repeat (2 * HALF) @(posedge pclk);
		do apb(1'b0, 8'h10, 32'h0); while (r[0] !== 1'b0);
	endtask
	task automatic byte_wait;
		do apb(1'b0, 8'h10, 32'h0); while (r[1] !== 1'b1);
	endtask
	task automatic refuse(input logic [31:0] ctl, input logic [31:0] st);
		apb(1'b1, 8'h00, ctl);
		repeat (2 * HALF) @(posedge pclk);
		rc(8'h10, st);
		apb(1'b1, 8'h10, 32'h8);
	endtask
	task automatic wrap(input logic [7:0] w);
		apb(1'b1, 8'h08, {20'h00004, w});
		apb(1'b1, 8'h00, 32'h25);
		idle;
	endtask
	task automatic run(input logic [31:0] ctl, input logic [23:0] a,
			input int n, input logic [23:0] m);
		logic [23:0] e;
		e = a;
		apb(1'b1, 8'h04, {8'h00, a});
		apb(1'b1, 8'h0C, 32'(n));
		apb(1'b1, 8'h00, ctl);
		repeat (n) begin
			byte_wait;
			apb(1'b0, 8'h14, 32'h0);
			chk({24'h0, r[7:0]}, {24'h0, u_fl.mem_byte(e)});
			e = (e & ~m) | ((e + 24'h1) & m);
		end
		idle;
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc(8'h08, 32'h410);
		rc(8'h0C, 32'h1);
		rc(8'h00, 32'h0);
		rc(8'h18, 32'h0);
		chk({31'h0, er}, 32'h1);
		refuse(32'h03, 32'h8);
		refuse(32'h2D, 32'h8);
		rc(8'h10, 32'h0);
		run(32'h21, 24'h123456, 2, 24'hFFFFFF);
		run(32'h21, 24'hFFFFFF, 2, 24'hFFFFFF);
		for (int i = 0; i < 4; i++) begin
			s = 24'h8 << i;
			wrap({1'b0, i[1:0], 5'h00});
			run(32'h23, 24'h100 + s - 24'h2, 3, s - 24'h1);
		end
		run(32'h23, 24'hABCD3E, 3, 24'h3F);
		four_line_command_mode <= 1'b1;
		run(32'h2B, 24'h00013E, 3, 24'hFFFFFF);
		run(32'h3B, 24'h000200, 1, 24'hFFFFFF);
		run(32'h2B, 24'h000300, 1, 24'hFFFFFF);
		dm <= 4'h2;
		apb(1'b1, 8'h08, 32'h260);
		run(32'h2B, 24'h000400, 2, 24'hFFFFFF);
		dm <= 4'h4;
		four_line_command_mode <= 1'b0;
		wrap(8'h10);
		run(32'h23, 24'h0001FE, 3, 24'hFFFFFF);
		run(32'h33, 24'h000010, 1, 24'hFFFFFF);
		rc(8'h10, 32'h4);
		run(32'h33, 24'h000020, 2, 24'hFFFFFF);
		run(32'h23, 24'h000030, 1, 24'hFFFFFF);
		rc(8'h10, 32'h0);
		run(32'h33, 24'h000040, 1, 24'hFFFFFF);
		refuse(32'h21, 32'hC);
		apb(1'b1, 8'h00, 32'h27);
		idle;
		rc(8'h10, 32'h0);
		run(32'h21, 24'h000050, 1, 24'hFFFFFF);
		// A busy flash leaves the lines alone, so they read back flat
		wip <= 1'b1;
		s = {20'h00000, dq};
		apb(1'b1, 8'h00, 32'h21);
		byte_wait;
		rc(8'h14, {24'h0, s[3:0], s[3:0]});
		idle;
		wip <= 1'b0;
		// Abort while the link is held by an unread byte
		apb(1'b1, 8'h0C, 32'h4);
		apb(1'b1, 8'h00, 32'h21);
		byte_wait;
		apb(1'b1, 8'h00, 32'h40);
		idle;
		rc(8'h10, 32'h2);
		rc(8'h14, {24'h0, u_fl.mem_byte(24'h000050)});
		apb(1'b1, 8'h0C, 32'h4);
		apb(1'b1, 8'h00, 32'h21);
		byte_wait;
		apb(1'b0, 8'h14, 32'h0);
		apb(1'b1, 8'h00, 32'h40);
		idle;
		rc(8'h10, 32'h0);
		chk({31'h0, cs_n}, 32'h1);
		conclude;
	end
endmodule
`default_nettype wire
